// ### sim/core_status_and_bank_select_tb_top.sv
// testbench for the core status and bank select block
`timescale 1ns/1ps

module core_status_and_bank_select_tb_top;
	// ====
	// signals
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic wdt_halt_rst_in = 1'b0, wdt_clear_in = 1'b0, halt_in = 1'b0, wdt_expire_in = 1'b0, tbl_req_in = 1'b0;
	csb_pkg::csb_access_type acc_in = '0;
	csb_pkg::csb_alu_type alu_in = '0;
	logic [12:0] pc_in = 13'h1234;
	logic [15:0] tbl_word_in = 16'h0000;
	logic [7:0] acc_rdata_out, alu_result_out, tbl_low_out, flags_out, mem_rdata_in;
	logic pc_load_out, dummy_cycle_out;
	logic [12:0] pc_target_out;
	logic [15:0] tbl_addr_out;
	csb_pkg::csb_mem_type mem_out;
	logic [1:0] bank_out;
	int miscompares = 0;
	int compares = 0;
	always #12.5 mclk_in = ~mclk_in;
	csb_core dut_u (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .wdt_halt_rst_in(wdt_halt_rst_in),
		.wdt_clear_in(wdt_clear_in), .halt_in(halt_in), .wdt_expire_in(wdt_expire_in),
		.acc_in(acc_in), .acc_rdata_out(acc_rdata_out),
		.alu_in(alu_in), .alu_result_out(alu_result_out),
		.pc_in(pc_in), .pc_load_out(pc_load_out), .pc_target_out(pc_target_out),
		.dummy_cycle_out(dummy_cycle_out),
		.tbl_req_in(tbl_req_in), .tbl_addr_out(tbl_addr_out),
		.tbl_word_in(tbl_word_in), .tbl_low_out(tbl_low_out),
		.mem_out(mem_out), .mem_rdata_in(mem_rdata_in),
		.flags_out(flags_out), .bank_out(bank_out)
	);
	csb_mem_model mem_u (.mclk_in(mclk_in), .mem_in(mem_out), .rdata_out(mem_rdata_in));
	// ====
	// shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (miscompares == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic op(input logic w, input logic ind, input logic two, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		acc_in <= '{rd: !w, wr: w, indirect: ind, use_two: two, addr: a, wdata: d};
		@(posedge mclk_in);
		acc_in <= '0;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		op(1'b1, 1'b0, 1'b0, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		op(1'b0, 1'b0, 1'b0, a, 8'h00);
		chk(acc_rdata_out, exp);
	endtask
	task automatic pulse(input logic [2:0] e);
		@(posedge mclk_in);
		{halt_in, wdt_expire_in, wdt_clear_in} <= e;
		@(posedge mclk_in);
		{halt_in, wdt_expire_in, wdt_clear_in} <= 3'h0;
		#1;
	endtask
	task automatic alu(input csb_pkg::csb_op_type o, input logic [7:0] a, input logic [7:0] b, input logic [7:0] r,
		input logic [3:0] m, input logic [3:0] f);
		@(posedge mclk_in);
		alu_in <= '{op: o, a: a, b: b};
		@(posedge mclk_in);
		alu_in <= '0;
		#1;
		chk(alu_result_out, r);
		chk(flags_out[3:0] & m, f);
	endtask
	// ====
	// scenarios
	task automatic t_reset();
		rdc(csb_pkg::ADDR_BANK_SEL, 8'h00);
		rdc(csb_pkg::ADDR_FLAGS, 8'h00);
	endtask
	task automatic t_bank();
		wr(csb_pkg::ADDR_BANK_SEL, 8'hff);
		rdc(csb_pkg::ADDR_BANK_SEL, 8'h03);
		for (int b = 0; b < 3; b++) begin
			wr(csb_pkg::ADDR_BANK_SEL, 8'(b));
			chk(16'(bank_out), 16'(b));
			wr(csb_pkg::ADDR_PTR_TWO, 8'h50);
			op(1'b1, 1'b1, 1'b1, csb_pkg::ADDR_PORT_TWO, 8'ha0 + 8'(b));
			chk(mem_u.mem[b][8'h50], 8'ha0 + 8'(b));
			op(1'b0, 1'b1, 1'b1, csb_pkg::ADDR_PORT_TWO, 8'h00);
			chk(acc_rdata_out, 8'ha0 + 8'(b));
		end
		wr(csb_pkg::ADDR_PTR_ONE, 8'h60);
		op(1'b1, 1'b1, 1'b0, csb_pkg::ADDR_PORT_ONE, 8'h11);
		chk(mem_u.mem[0][8'h60], 8'h11);
		wr(8'h61, 8'h22);
		chk(mem_u.mem[0][8'h61], 8'h22);
		rdc(8'h61, 8'h22);
		wr(csb_pkg::ADDR_PTR_TWO, csb_pkg::ADDR_WORKING);
		op(1'b1, 1'b1, 1'b1, csb_pkg::ADDR_PORT_TWO, 8'h5a);
		rdc(csb_pkg::ADDR_WORKING, 8'h5a);
		rdc(csb_pkg::ADDR_BANK_SEL, 8'h02);
		wr(csb_pkg::ADDR_PTR_TWO, csb_pkg::ADDR_PORT_TWO);
		op(1'b0, 1'b1, 1'b1, csb_pkg::ADDR_PORT_TWO, 8'h00);
		chk(acc_rdata_out, 8'h00);
		wr(csb_pkg::ADDR_BANK_SEL, 8'h03);
		wr(csb_pkg::ADDR_PTR_TWO, 8'h50);
		op(1'b1, 1'b1, 1'b1, csb_pkg::ADDR_PORT_TWO, 8'h77);
		op(1'b0, 1'b1, 1'b1, csb_pkg::ADDR_PORT_TWO, 8'h00);
		chk(acc_rdata_out, 8'h00);
		@(posedge mclk_in);
		wdt_halt_rst_in <= 1'b1;
		acc_in <= '{rd: 1'b0, wr: 1'b1, indirect: 1'b0, use_two: 1'b0, addr: csb_pkg::ADDR_BANK_SEL, wdata: 8'h01};
		@(posedge mclk_in);
		wdt_halt_rst_in <= 1'b0;
		acc_in <= '0;
		#1;
		chk(16'(bank_out), 16'h0003);
		@(posedge mclk_in);
		sys_rst_in <= 1'b1;
		@(posedge mclk_in);
		sys_rst_in <= 1'b0;
		#1;
		chk(16'(bank_out), 16'h0000);
	endtask
	task automatic t_pc();
		wr(csb_pkg::ADDR_PC_LOW, 8'h55);
		chk({pc_load_out, dummy_cycle_out, pc_target_out}, {1'b0, 2'b11, 13'h1255});
		@(posedge mclk_in);
		#1;
		chk({pc_load_out, dummy_cycle_out}, 16'h0000);
	endtask
	task automatic t_flags();
		wr(csb_pkg::ADDR_FLAGS, 8'hff);
		rdc(csb_pkg::ADDR_FLAGS, 8'h0f);
		pulse(3'b100);
		chk(flags_out, 8'h1f);
		pulse(3'b010);
		chk(flags_out, 8'h3f);
		pulse(3'b100);
		chk(flags_out, 8'h1f);
		pulse(3'b001);
		chk(flags_out, 8'h0f);
		pulse(3'b011);
		chk(flags_out, 8'h2f);
		wr(csb_pkg::ADDR_FLAGS, 8'h00);
	endtask
	task automatic t_alu();
		alu(csb_pkg::CSB_OP_ADD, 8'hff, 8'h01, 8'h00, 4'hf, 4'b0111);
		alu(csb_pkg::CSB_OP_ADD, 8'h7f, 8'h01, 8'h80, 4'hf, 4'b1010);
		alu(csb_pkg::CSB_OP_SUB, 8'h80, 8'h01, 8'h7f, 4'hf, 4'b1001);
		alu(csb_pkg::CSB_OP_SUB, 8'h03, 8'h05, 8'hfe, 4'hf, 4'b0000);
		alu(csb_pkg::CSB_OP_LOGIC, 8'h00, 8'h00, 8'h00, 4'hf, 4'b0100);
		alu(csb_pkg::CSB_OP_RLC, 8'h80, 8'h00, 8'h00, 4'h1, 4'h1);
		alu(csb_pkg::CSB_OP_RRC, 8'h00, 8'h00, 8'h80, 4'h1, 4'h0);
	endtask
	task automatic t_table();
		wr(csb_pkg::ADDR_TBL_LOW, 8'h34);
		wr(csb_pkg::ADDR_TBL_HIGH, 8'h12);
		chk(tbl_addr_out, 16'h1234);
		@(posedge mclk_in);
		tbl_req_in <= 1'b1;
		tbl_word_in <= 16'habcd;
		@(posedge mclk_in);
		tbl_req_in <= 1'b0;
		#1;
		chk(tbl_low_out, 8'hcd);
		rdc(csb_pkg::ADDR_TBL_DATA, 8'hab);
	endtask
	// ====
	// main sequence
	initial begin
		repeat (3) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_bank();
		t_pc();
		t_flags();
		t_alu();
		t_table();
		complete_run();
	end
	initial begin
		#100us;
		miscompares++;
		complete_run();
	end
endmodule

// ### sim/csb_core_props.sv
// assertions for the core status and bank select block
`timescale 1ns/1ps

module csb_core_props (
	// clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// inputs
	input wire logic wdt_halt_rst_in,
	input wire logic wdt_clear_in,
	input wire logic halt_in,
	input wire logic wdt_expire_in,
	input wire csb_pkg::csb_access_type acc_in,
	input wire csb_pkg::csb_alu_type alu_in,
	input wire logic [12:0] pc_in,
	input wire logic tbl_req_in,
	input wire logic [15:0] tbl_word_in,
	// outputs
	input wire logic pc_load_out,
	input wire logic [12:0] pc_target_out,
	input wire logic dummy_cycle_out,
	input wire logic [7:0] tbl_low_out,
	input wire csb_pkg::csb_mem_type mem_out,
	input wire logic [7:0] alu_result_out,
	input wire logic [7:0] flags_out,
	input wire logic [1:0] bank_out
);
	// ====
	// helpers
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	wire logic dwr = acc_in.wr && !acc_in.indirect;
	wire logic flag_wr = dwr && acc_in.addr == csb_pkg::ADDR_FLAGS;
	wire logic two_pair = acc_in.indirect && acc_in.use_two;
	// ====
	// assertions
	bank_write_a:
	assert property (dwr && acc_in.addr == csb_pkg::ADDR_BANK_SEL && !wdt_halt_rst_in |=> bank_out == $past(acc_in.wdata[1:0]))
	else $error("bank field not loaded");
	direct_bank_a:
	assert property (dwr && acc_in.addr >= csb_pkg::SFR_LIMIT |-> mem_out.wr && mem_out.bank == 2'h0)
	else $error("direct write left bank zero");
	special_area_a:
	assert property (!acc_in.indirect && acc_in.addr < csb_pkg::SFR_LIMIT |-> !mem_out.rd && !mem_out.wr)
	else $error("special area reached memory");
	pc_jump_a:
	assert property (dwr && acc_in.addr == csb_pkg::ADDR_PC_LOW |=> pc_load_out && pc_target_out == {$past(pc_in[12:8]), $past(acc_in.wdata)})
	else $error("pc low write did not jump");
	dummy_once_a:
	assert property (dwr && acc_in.addr == csb_pkg::ADDR_PC_LOW |=> dummy_cycle_out ##1 !dummy_cycle_out)
	else $error("dummy cycle wrong");
	flag_keep_a:
	assert property (flag_wr && !wdt_clear_in && !halt_in && !wdt_expire_in |=> flags_out[5:4] == $past(flags_out[5:4]))
	else $error("flag write changed system flags");
	halt_flags_a:
	assert property (halt_in && !wdt_expire_in |=> flags_out[5:4] == 2'b01)
	else $error("halt flags wrong");
	expire_flag_a:
	assert property (wdt_expire_in |=> flags_out[5])
	else $error("expiry flag not set");
	clear_flags_a:
	assert property (wdt_clear_in && !halt_in && !wdt_expire_in |=> flags_out[5:4] == 2'b00)
	else $error("clear left system flags");
	pair_bank_a:
	assert property ((mem_out.rd || mem_out.wr) && acc_in.indirect |-> mem_out.bank == (acc_in.use_two ? bank_out : 2'h0))
	else $error("indirect pair bank wrong");
	undef_bank_a:
	assert property (two_pair && bank_out == csb_pkg::BANK_UNDEF |-> !mem_out.rd && !mem_out.wr)
	else $error("undefined bank reached memory");
	table_low_a:
	assert property (tbl_req_in |=> tbl_low_out == $past(tbl_word_in[7:0]))
	else $error("table low byte wrong");
	zero_flag_a:
	assert property (alu_in.op == csb_pkg::CSB_OP_ADD && !flag_wr |=> flags_out[2] == (alu_result_out == 8'h00))
	else $error("zero flag wrong");
	bank_hold_a:
	assert property (wdt_halt_rst_in |=> bank_out == $past(bank_out))
	else $error("bank changed during watchdog halt reset");
	// ====
	// covers
	cover property (pc_load_out);
	cover property (two_pair && mem_out.wr);
	cover property (tbl_req_in);
	cover property (wdt_halt_rst_in);
endmodule

bind csb_core csb_core_props chk_u (
	.mclk_in(mclk_in),
	.sys_rst_in(sys_rst_in),
	.wdt_halt_rst_in(wdt_halt_rst_in),
	.wdt_clear_in(wdt_clear_in),
	.halt_in(halt_in),
	.wdt_expire_in(wdt_expire_in),
	.acc_in(acc_in),
	.alu_in(alu_in),
	.pc_in(pc_in),
	.tbl_req_in(tbl_req_in),
	.tbl_word_in(tbl_word_in),
	.pc_load_out(pc_load_out),
	.pc_target_out(pc_target_out),
	.dummy_cycle_out(dummy_cycle_out),
	.tbl_low_out(tbl_low_out),
	.mem_out(mem_out),
	.alu_result_out(alu_result_out),
	.flags_out(flags_out),
	.bank_out(bank_out)
);

// ### sim/csb_mem_model.sv
// banked data memory model on the far side of the block
`timescale 1ns/1ps

module csb_mem_model (
	// clock
	input wire logic mclk_in,
	// request and answer
	input wire csb_pkg::csb_mem_type mem_in,
	output logic [7:0] rdata_out
);
	// ====
	// storage
	logic [7:0] mem [0:2][0:255];
	logic [7:0] last = 8'h00;
	// reads answer in the same cycle; an idle bus shows the inverse of the last value
	assign rdata_out = (mem_in.rd && mem_in.bank != 2'h3) ? mem[mem_in.bank][mem_in.addr] : ~last;
	always @(posedge mclk_in) begin
		if (mem_in.rd)
			last <= rdata_out;
		if (mem_in.wr && mem_in.bank != 2'h3)
			mem[mem_in.bank][mem_in.addr] <= mem_in.wdata;
	end
endmodule

// ### src/csb_core.sv
// core status flags, bank select, pc low byte and table read logic
//
// Operation
// - bank chosen by bank select bits 1:0
// - codes 00,01,10 give banks zero to two
// - reset clears bank, except watchdog during halt
// - special register area ignores bank selection
// - direct addresses always reach bank zero
// - bank select upper six bits read zero
// - pc low write jumps within page
// - pc low write adds one dummy cycle
// - table read splits word high and low
// - flag writes keep watchdog and halt flags
// - carry bit 0 from add, sub, rotate
// - half carry bit 1 from low nibble
// - zero bit 2 when add, sub or logic result zero
// - overflow bit 3 carry in xor out
// - halt flag: power-up, clear clears, halt sets
// - watchdog flag: set by expiry, cleared by clear or halt
// - flags never saved automatically on calls
// - no register to register transfer path
// - flag bits 7:6 zero, system flags reset zero
// - second pair uses bank, first pair bank zero
// - indirect port via indirect reads zero, ignored
`timescale 1ns/1ps

module csb_core (
	// clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// reset cause
	input wire logic wdt_halt_rst_in,
	// system events
	input wire logic wdt_clear_in,
	input wire logic halt_in,
	input wire logic wdt_expire_in,
	// register access
	input wire csb_pkg::csb_access_type acc_in,
	output logic [7:0] acc_rdata_out,
	// alu
	input wire csb_pkg::csb_alu_type alu_in,
	output logic [7:0] alu_result_out,
	// program counter
	input wire logic [12:0] pc_in,
	output logic pc_load_out,
	output logic [12:0] pc_target_out,
	output logic dummy_cycle_out,
	// table read
	input wire logic tbl_req_in,
	output logic [15:0] tbl_addr_out,
	input wire logic [15:0] tbl_word_in,
	output logic [7:0] tbl_low_out,
	// data memory
	output csb_pkg::csb_mem_type mem_out,
	input wire logic [7:0] mem_rdata_in,
	// state
	output logic [7:0] flags_out,
	output logic [1:0] bank_out
);

	// ==========================================
	// functions
	function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic cin);
		add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	endfunction

	function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b, input logic cin);
		add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
	endfunction

	function automatic logic reg_sel(input logic [7:0] a, input logic [7:0] r);
		reg_sel = a == r;
	endfunction

	// ==========================================
	// registers
	logic [1:0] bank_reg;
	logic [1:0] bank_next;
	logic [3:0] arith_reg;
	logic [3:0] arith_next;
	logic pdn_reg;
	logic pdn_next;
	logic wdx_reg;
	logic wdx_next;
	logic [7:0] ptr_one_reg;
	logic [7:0] ptr_two_reg;
	logic [7:0] working_reg;
	logic [7:0] tbl_low_reg;
	logic [7:0] tbl_high_reg;
	logic [7:0] tbl_data_reg;
	logic [7:0] alu_result_reg;
	logic [7:0] tbl_dest_reg;
	logic pc_load_reg;
	logic [12:0] pc_target_reg;
	csb_pkg::csb_state_type state_reg;
	csb_pkg::csb_state_type state_next;
	logic [7:0] rdata_reg;

	// ==========================================
	// address decode
	wire logic sfr_hit;
	wire logic direct_acc;
	wire logic ind_one;
	wire logic ind_two;
	wire logic [7:0] eff_addr;
	wire logic eff_sfr;
	wire logic port_self;
	wire logic undef_bank;
	wire logic dead_acc;
	wire logic [1:0] eff_bank;
	wire logic sfr_wr;
	wire logic sfr_rd;

	assign direct_acc = !acc_in.indirect;
	assign ind_one = acc_in.indirect && !acc_in.use_two;
	assign ind_two = acc_in.indirect && acc_in.use_two;
	// indirect goes through the pointer, direct uses the instruction address
	assign eff_addr = ind_one ? ptr_one_reg : (ind_two ? ptr_two_reg : acc_in.addr);
	assign eff_sfr = eff_addr < csb_pkg::SFR_LIMIT;
	assign port_self = acc_in.indirect && (eff_addr == csb_pkg::ADDR_PORT_ONE || eff_addr == csb_pkg::ADDR_PORT_TWO);
	assign undef_bank = ind_two && (bank_reg == csb_pkg::BANK_UNDEF) && !eff_sfr;
	assign dead_acc = port_self || undef_bank;
	assign sfr_hit = eff_sfr && !port_self;
	// bank zero for direct and first pair, bank field for second pair
	assign eff_bank = (direct_acc || ind_one) ? csb_pkg::BANK_RESET : bank_reg;
	assign sfr_wr = acc_in.wr && sfr_hit;
	assign sfr_rd = acc_in.rd && sfr_hit;

	wire logic wr_bank;
	wire logic wr_flags;
	wire logic wr_pcl;
	wire logic wr_ptr_one;
	wire logic wr_ptr_two;
	wire logic wr_working;
	wire logic wr_tbl_low;
	wire logic wr_tbl_high;
	wire logic wr_tbl_data;

	assign wr_bank = sfr_wr && reg_sel(eff_addr, csb_pkg::ADDR_BANK_SEL);
	assign wr_flags = sfr_wr && reg_sel(eff_addr, csb_pkg::ADDR_FLAGS);
	assign wr_pcl = sfr_wr && reg_sel(eff_addr, csb_pkg::ADDR_PC_LOW);
	assign wr_ptr_one = sfr_wr && reg_sel(eff_addr, csb_pkg::ADDR_PTR_ONE);
	assign wr_ptr_two = sfr_wr && reg_sel(eff_addr, csb_pkg::ADDR_PTR_TWO);
	assign wr_working = sfr_wr && reg_sel(eff_addr, csb_pkg::ADDR_WORKING);
	assign wr_tbl_low = sfr_wr && reg_sel(eff_addr, csb_pkg::ADDR_TBL_LOW);
	assign wr_tbl_high = sfr_wr && reg_sel(eff_addr, csb_pkg::ADDR_TBL_HIGH);
	assign wr_tbl_data = sfr_wr && reg_sel(eff_addr, csb_pkg::ADDR_TBL_DATA);

	// ==========================================
	// register read mux
	wire logic [7:0] flags_view;
	wire logic [7:0] sfr_rdata;

	assign flags_view = {2'b00, wdx_reg, pdn_reg, arith_reg};
	assign sfr_rdata =
		(eff_addr == csb_pkg::ADDR_PTR_ONE) ? ptr_one_reg :
		(eff_addr == csb_pkg::ADDR_PTR_TWO) ? ptr_two_reg :
		(eff_addr == csb_pkg::ADDR_BANK_SEL) ? {6'h00, bank_reg} :
		(eff_addr == csb_pkg::ADDR_WORKING) ? working_reg :
		(eff_addr == csb_pkg::ADDR_PC_LOW) ? pc_in[7:0] :
		(eff_addr == csb_pkg::ADDR_TBL_LOW) ? tbl_low_reg :
		(eff_addr == csb_pkg::ADDR_TBL_DATA) ? tbl_data_reg :
		(eff_addr == csb_pkg::ADDR_TBL_HIGH) ? tbl_high_reg :
		(eff_addr == csb_pkg::ADDR_FLAGS) ? flags_view :
		csb_pkg::REG_RESET;

	// data memory outside the special area; memory to memory goes via working reg
	assign mem_out.rd = acc_in.rd && !eff_sfr && !dead_acc;
	assign mem_out.wr = acc_in.wr && !eff_sfr && !dead_acc;
	assign mem_out.bank = eff_bank;
	assign mem_out.addr = eff_addr;
	assign mem_out.wdata = acc_in.wdata;

	// ==========================================
	// alu and flags
	wire logic [8:0] sum9;
	wire logic [4:0] sum5;
	wire logic [8:0] low9;
	wire logic c_in7;
	wire logic [7:0] b_eff;
	wire logic cin_eff;
	wire logic arith_op;
	wire logic [7:0] res;
	wire logic [3:0] alu_flags;

	// subtraction is a plus not-b plus one, so carry means no borrow
	assign arith_op = alu_in.op == csb_pkg::CSB_OP_ADD || alu_in.op == csb_pkg::CSB_OP_SUB;
	assign b_eff = (alu_in.op == csb_pkg::CSB_OP_SUB) ? ~alu_in.b : alu_in.b;
	assign cin_eff = alu_in.op == csb_pkg::CSB_OP_SUB;
	assign sum9 = add9(alu_in.a, b_eff, cin_eff);
	assign sum5 = add5(alu_in.a[3:0], b_eff[3:0], cin_eff);
	assign low9 = add9({1'b0, alu_in.a[6:0]}, {1'b0, b_eff[6:0]}, cin_eff);
	assign c_in7 = low9[7];
	assign res =
		arith_op ? sum9[7:0] :
		(alu_in.op == csb_pkg::CSB_OP_RLC) ? {alu_in.a[6:0], arith_reg[csb_pkg::FLAG_CARRY]} :
		(alu_in.op == csb_pkg::CSB_OP_RRC) ? {arith_reg[csb_pkg::FLAG_CARRY], alu_in.a[7:1]} :
		alu_in.b;

	assign alu_flags[csb_pkg::FLAG_CARRY] =
		arith_op ? sum9[8] :
		(alu_in.op == csb_pkg::CSB_OP_RLC) ? alu_in.a[7] :
		(alu_in.op == csb_pkg::CSB_OP_RRC) ? alu_in.a[0] :
		arith_reg[csb_pkg::FLAG_CARRY];
	assign alu_flags[csb_pkg::FLAG_HALF] = arith_op ? sum5[4] : arith_reg[csb_pkg::FLAG_HALF];
	assign alu_flags[csb_pkg::FLAG_ZERO] =
		(arith_op || alu_in.op == csb_pkg::CSB_OP_LOGIC) ? (res == 8'h00) : arith_reg[csb_pkg::FLAG_ZERO];
	assign alu_flags[csb_pkg::FLAG_OVF] = arith_op ? (c_in7 ^ sum9[8]) : arith_reg[csb_pkg::FLAG_OVF];

	// flag writes touch only the arithmetic nibble
	assign arith_next = wr_flags ? (acc_in.wdata[3:0] & csb_pkg::FLAG_WR_MASK[3:0]) : alu_flags;
	// halt sets, clear instruction clears
	assign pdn_next = halt_in ? 1'b1 : (wdt_clear_in ? 1'b0 : pdn_reg);
	// expiry sets and wins over a clear in the same cycle
	assign wdx_next = wdt_expire_in ? 1'b1 : ((wdt_clear_in || halt_in) ? 1'b0 : wdx_reg);

	// ==========================================
	// bank select
	assign bank_next = wr_bank ? (acc_in.wdata[1:0] & csb_pkg::BANK_MASK[1:0]) : bank_reg;

	// ==========================================
	// next register values
	wire logic [7:0] ptr_one_next;
	wire logic [7:0] ptr_two_next;
	wire logic [7:0] working_next;
	wire logic [7:0] tbl_low_next;
	wire logic [7:0] tbl_high_next;
	wire logic [12:0] pc_target_next;
	wire logic [7:0] rdata_next;

	assign ptr_one_next = wr_ptr_one ? acc_in.wdata : ptr_one_reg;
	assign ptr_two_next = wr_ptr_two ? acc_in.wdata : ptr_two_reg;
	assign working_next = wr_working ? acc_in.wdata : working_reg;
	assign tbl_low_next = wr_tbl_low ? acc_in.wdata : tbl_low_reg;
	assign tbl_high_next = wr_tbl_high ? acc_in.wdata : tbl_high_reg;
	assign pc_target_next = wr_pcl ? {pc_in[12:8], acc_in.wdata} : pc_target_reg;
	assign rdata_next = sfr_rd ? sfr_rdata : (acc_in.rd ? (mem_rdata_in & {8{!dead_acc}}) : rdata_reg);

	// ==========================================
	// pc low byte jump and dummy cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			csb_pkg::CSB_ST_RUN: begin
				if (wr_pcl) begin
					state_next = csb_pkg::CSB_ST_DUMMY;
				end
			end
			csb_pkg::CSB_ST_DUMMY: begin
				state_next = csb_pkg::CSB_ST_RUN;
			end
			default: begin
				state_next = csb_pkg::CSB_ST_RUN;
			end
		endcase
	end

	// ==========================================
	// sequential logic
	// bank: kept only by a watchdog reset taken while halted
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bank_reg <= csb_pkg::BANK_RESET;
		end else if (wdt_halt_rst_in) begin
			bank_reg <= bank_reg;
		end else begin
			bank_reg <= bank_next;
		end
	end

	// flags are plain state, the call path never stacks them
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			arith_reg <= csb_pkg::ARITH_RESET;
			pdn_reg <= 1'b0;
			wdx_reg <= 1'b0;
		end else begin
			arith_reg <= arith_next;
			pdn_reg <= pdn_next;
			wdx_reg <= wdx_next;
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ptr_one_reg <= csb_pkg::REG_RESET;
			ptr_two_reg <= csb_pkg::REG_RESET;
			working_reg <= csb_pkg::REG_RESET;
			tbl_low_reg <= csb_pkg::REG_RESET;
			tbl_high_reg <= csb_pkg::REG_RESET;
		end else begin
			ptr_one_reg <= ptr_one_next;
			ptr_two_reg <= ptr_two_next;
			working_reg <= working_next;
			tbl_low_reg <= tbl_low_next;
			tbl_high_reg <= tbl_high_next;
		end
	end

	// table read: high byte to data reg, low byte to destination
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tbl_data_reg <= csb_pkg::REG_RESET;
			tbl_dest_reg <= csb_pkg::REG_RESET;
		end else if (tbl_req_in) begin
			tbl_data_reg <= tbl_word_in[15:8];
			tbl_dest_reg <= tbl_word_in[7:0];
		end else if (wr_tbl_data) begin
			tbl_data_reg <= acc_in.wdata;
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= csb_pkg::CSB_ST_RUN;
			pc_load_reg <= 1'b0;
			pc_target_reg <= 13'h0000;
		end else begin
			state_reg <= state_next;
			pc_load_reg <= wr_pcl;
			pc_target_reg <= pc_target_next;
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			alu_result_reg <= csb_pkg::REG_RESET;
			rdata_reg <= csb_pkg::REG_RESET;
		end else begin
			alu_result_reg <= res;
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================
	// outputs
	assign acc_rdata_out = rdata_reg;
	assign alu_result_out = alu_result_reg;
	assign pc_load_out = pc_load_reg;
	assign pc_target_out = pc_target_reg;
	assign dummy_cycle_out = state_reg == csb_pkg::CSB_ST_DUMMY;
	assign tbl_addr_out = {tbl_high_reg, tbl_low_reg};
	assign tbl_low_out = tbl_dest_reg;
	assign flags_out = flags_view;
	assign bank_out = bank_reg;

endmodule

// ### src/csb_pkg.sv
// package for the core status and bank select block
package csb_pkg;

	// special function register addresses
	localparam logic [7:0] ADDR_PORT_ONE = 8'h00;
	localparam logic [7:0] ADDR_PTR_ONE = 8'h01;
	localparam logic [7:0] ADDR_PORT_TWO = 8'h02;
	localparam logic [7:0] ADDR_PTR_TWO = 8'h03;
	localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
	localparam logic [7:0] ADDR_WORKING = 8'h05;
	localparam logic [7:0] ADDR_PC_LOW = 8'h06;
	localparam logic [7:0] ADDR_TBL_LOW = 8'h07;
	localparam logic [7:0] ADDR_TBL_DATA = 8'h08;
	localparam logic [7:0] ADDR_TBL_HIGH = 8'h09;
	localparam logic [7:0] ADDR_FLAGS = 8'h0a;
	localparam logic [7:0] SFR_LIMIT = 8'h40;

	// field positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_HALF = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_OVF = 3;
	localparam int FLAG_PDN = 4;
	localparam int FLAG_WDX = 5;
	localparam logic [7:0] FLAG_WR_MASK = 8'h0f;
	localparam logic [7:0] BANK_MASK = 8'h03;

	// reset values
	localparam logic [1:0] BANK_RESET = 2'h0;
	localparam logic [3:0] ARITH_RESET = 4'h0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] BANK_UNDEF = 2'h3;

	// alu operations
	typedef enum logic [2:0] {
		CSB_OP_NONE = 3'b000,
		CSB_OP_ADD = 3'b001,
		CSB_OP_SUB = 3'b010,
		CSB_OP_LOGIC = 3'b011,
		CSB_OP_RLC = 3'b100,
		CSB_OP_RRC = 3'b101
	} csb_op_type;

	// pc sequencing states
	typedef enum logic [0:0] {
		CSB_ST_RUN = 1'b0,
		CSB_ST_DUMMY = 1'b1
	} csb_state_type;

	// register access from the execution unit
	typedef struct packed {
		logic rd;
		logic wr;
		logic indirect;
		logic use_two;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csb_access_type;

	// data memory request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [1:0] bank;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csb_mem_type;

	// alu request
	typedef struct packed {
		csb_op_type op;
		logic [7:0] a;
		logic [7:0] b;
	} csb_alu_type;

endpackage
